// [dv/sat_rx_model.sv]
// behavioural far-end receiver that decodes frames off the serial line
`timescale 1ns/10ps
module sat_rx_model (
  // clock
  input  wire logic        clk_i,
  // serial line and its drive enable
  input  wire logic        line_i,
  input  wire logic        oe_i,
  // line setup
  input  wire logic [15:0] bit_clks_i,
  input  wire logic        nine_i,
  // decoded word
  output logic      [8:0]  word_o,
  output logic             stop_ok_o,
  output int               count_o
);
  logic       level;
  logic [8:0] acc;
  int         n;

  // an undriven line rests at the pull-up level
  assign level = oe_i ? line_i : 1'b1;

  // start detect, then mid-bit sampling; an all-high idle frame never starts a word
  initial begin
    word_o = 9'h000;
    stop_ok_o = 1'b0;
    count_o = 0;
    forever begin
      @(posedge clk_i);
      if (level === 1'b0) begin
        n = nine_i ? 9 : 8;
        acc = 9'h000;
        repeat (bit_clks_i / 2) @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
          repeat (bit_clks_i) @(posedge clk_i);
          acc[i] = level;
        end
        repeat (bit_clks_i) @(posedge clk_i);
        stop_ok_o = (level === 1'b1);
        word_o = acc;
        count_o = count_o + 1;
      end
    end
  end
endmodule : sat_rx_model

// [dv/tb_sat_top.sv]
// self-checking bench of the serial async transmitter
`timescale 1ns/10ps
module tb_sat_top;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int BAUD_VAL = 7; // bit time of 8 clocks keeps a frame longer than ten writes
  logic       clk;
  logic       srst;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       txd;
  logic       txd_oe;
  logic       irq;
  logic [8:0] rx_word;
  logic       rx_stop;
  logic       nine;
  logic [7:0] last_rd;
  int         rx_count;
  int         seen;
  int         cnt;
  int         bad_count;
  int         checks_done;

  // 50 MHz clock
  initial clk = 1'b0;
  always #10 clk = ~clk;

  sat_top sat_top_i (.CLK_I(clk), .SRST_I(srst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .TXD_O(txd), .TXD_OE_O(txd_oe), .IRQ_O(irq));

  sat_rx_model sat_rx_model_i (.clk_i(clk), .line_i(txd), .oe_i(txd_oe), .bit_clks_i(16'(BAUD_VAL + 1)),
    .nine_i(nine), .word_o(rx_word), .stop_ok_o(rx_stop), .count_o(rx_count));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  // one-cycle write strobe
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // read data is taken in the cycle after the strobe only
  task automatic rd_reg(input logic [2:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    last_rd = rdata;
  endtask : rd_reg

  // status access then data write, the sequence that clears both flags
  task automatic send(input logic [7:0] d);
    rd_reg(sat_pkg::ADDR_STATUS);
    wr_reg(sat_pkg::ADDR_DATA, d);
  endtask : send

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  // bounded wait for the receiver to finish one word
  task automatic wait_word(input logic [8:0] exp);
    int t;
    t = 0;
    while (rx_count == seen && t < 3000) begin
      @(posedge clk);
      t++;
    end
    if (t >= 3000) begin
      bad_count++;
      final_report();
    end
    seen = rx_count;
    check(rx_word, exp);
    check(rx_stop, 1'b1);
  endtask : wait_word

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    srst = 1'b1;
    addr = 3'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    nine = 1'b0;
    seen = 0;
    bad_count = 0;
    checks_done = 0;
    idle(8);
    check(txd, 1'b1);
    check(txd_oe, 1'b0);
    check(irq, 1'b0);
    srst <= 1'b0;
    // reset values; index 1 is write only and 6, 7 are unmapped
    rd_reg(sat_pkg::ADDR_STATUS);
    check(last_rd, 8'hC0);
    for (int i = 1; i < 8; i++) begin
      rd_reg(3'(i));
      check(last_rd, 8'h00);
    end
    // word length, then baud, then enable; line must stay high through the idle frame
    wr_reg(sat_pkg::ADDR_CTRL1, 8'h00);
    wr_reg(sat_pkg::ADDR_BAUD, 8'(BAUD_VAL));
    wr_reg(sat_pkg::ADDR_EXTP, 8'h00);
    wr_reg(sat_pkg::ADDR_CTRL2, 8'h08);
    cnt = 0;
    repeat (100) begin
      @(posedge clk);
      if (txd !== 1'b1) cnt++;
    end
    check(9'(cnt), 9'h000);
    check(txd_oe, 1'b1);
    // single word from idle: flag back up at once, complete after stop
    send(8'hA5);
    idle(4);
    rd_reg(sat_pkg::ADDR_STATUS);
    check(last_rd, 8'h80);
    wait_word(9'h0A5);
    idle(8);
    rd_reg(sat_pkg::ADDR_STATUS);
    check(last_rd, 8'hC0);
    // fill the buffer past full; the tenth write is dropped
    for (int i = 0; i < 10; i++) begin
      send(8'h10 + 8'(i));
    end
    rd_reg(sat_pkg::ADDR_STATUS);
    check(last_rd, 8'h01);
    for (int i = 0; i < 9; i++) begin
      wait_word(9'h010 + 9'(i));
    end
    idle(200);
    check(9'(rx_count - seen), 9'h000);
    // a data write with no status access first must not clear the flags
    wr_reg(sat_pkg::ADDR_DATA, 8'h0F);
    wait_word(9'h00F);
    idle(16);
    wr_reg(sat_pkg::ADDR_DATA, 8'h0E);
    idle(4);
    rd_reg(sat_pkg::ADDR_STATUS);
    check(last_rd, 8'hC0);
    wait_word(9'h00E);
    // nine-bit words, ninth bit set then clear
    wr_reg(sat_pkg::ADDR_CTRL1, 8'h50);
    nine <= 1'b1;
    send(8'h5A);
    wait_word(9'h15A);
    wr_reg(sat_pkg::ADDR_CTRL1, 8'h10);
    send(8'hFF);
    wait_word(9'h0FF);
    idle(16);
    wr_reg(sat_pkg::ADDR_CTRL1, 8'h00);
    nine <= 1'b0;
    // request from each flag, dropped by the clear sequence, back after the frame
    wr_reg(sat_pkg::ADDR_CTRL2, 8'h88);
    idle(3);
    check(irq, 1'b1);
    wr_reg(sat_pkg::ADDR_CTRL2, 8'h48);
    idle(3);
    check(irq, 1'b1);
    send(8'h66);
    idle(10);
    check(irq, 1'b0);
    wait_word(9'h066);
    idle(8);
    check(irq, 1'b1);
    wr_reg(sat_pkg::ADDR_CTRL2, 8'h08);
    idle(3);
    check(irq, 1'b0);
    final_report();
  end
endmodule : tb_sat_top

// [logic/sat_fifo.sv]
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/10ps
module sat_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     srst_i,
  // fill side
  input  wire logic                     in_valid_i,
  output logic                          in_ready_o,
  input  wire logic [WIDTH-1:0]         in_data_i,
  // drain side
  output logic                          out_valid_o,
  input  wire logic                     out_ready_i,
  output logic [WIDTH-1:0]              out_data_o,
  // fill level
  output logic [$clog2(DEPTH+1)-1:0]    level_o
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int LW = $clog2(DEPTH+1);

  // depth must be a power of two for the wrapping pointers
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("sat_fifo: DEPTH must be a power of two, 2 or more");
    end
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [LW-1:0]    level_r;
  logic             push;
  logic             pop;

  assign in_ready_o  = (level_r != LW'(DEPTH));
  assign out_valid_o = (level_r != '0);
  assign out_data_o  = mem_r[rd_ptr_r];
  assign level_o     = level_r;
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // storage, no reset needed on data
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  // pointers and level
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      level_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + AW'(1);
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + AW'(1);
      end
      if (push && !pop) begin
        level_r <= level_r + LW'(1);
      end else if (pop && !push) begin
        level_r <= level_r - LW'(1);
      end
    end
  end

endmodule : sat_fifo

// [logic/sat_pkg.sv]
// shared constants and types of the serial async transmitter
package sat_pkg;

  // ----------------------------------------------------------------
  // register map (word index on the register port)
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_STATUS = 3'h0;  // serial_status_reg
  localparam logic [2:0] ADDR_DATA   = 3'h1;  // serial_data_reg
  localparam logic [2:0] ADDR_CTRL1  = 3'h2;  // serial_control_reg1
  localparam logic [2:0] ADDR_CTRL2  = 3'h3;  // enables
  localparam logic [2:0] ADDR_BAUD   = 3'h4;  // baud_rate_reg
  localparam logic [2:0] ADDR_EXTP   = 3'h5;  // ext_tx_prescaler_reg

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int STAT_EMPTY_BIT   = 7;
  localparam int STAT_DONE_BIT    = 6;
  localparam int STAT_FULL_BIT    = 0;
  localparam int CR1_NINTH_BIT    = 6;
  localparam int CR1_WLEN_BIT     = 4;
  localparam int CR2_EMPTY_IE_BIT = 7;
  localparam int CR2_DONE_IE_BIT  = 6;
  localparam int CR2_ENABLE_BIT   = 3;

  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CTRL1   = 8'h00;
  localparam logic [7:0] RST_CTRL2   = 8'h00;
  localparam logic [7:0] RST_BAUD    = 8'h00;
  localparam logic [7:0] RST_EXTP    = 8'h00;
  localparam logic       RST_TX_BUFFER_EMPTY_FLAG    = 1'b1;
  localparam logic       RST_TC      = 1'b1;
  localparam logic [3:0] BITS_FRAME8 = 4'hA;  // start + 8 data + stop
  localparam logic [3:0] BITS_FRAME9 = 4'hB;  // start + 9 data + stop
  localparam int         FIFO_DEPTH  = 8;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
  } sat_word_type;

  typedef enum logic [1:0] {
    TX_OFF,
    TX_IDLE,
    TX_SEND
  } sat_state_type;

endpackage : sat_pkg

// [logic/sat_top.sv]
// transmit half of the asynchronous serial interface
`timescale 1ns/10ps

// How it works
// - word length select clear sends 8 data bits, set sends 9.
// - in 9-bit mode the ninth bit comes from tx_ninth_bit.
// - data bits leave on the line least significant bit first.
// - data register writes land in a buffer before the shifter.
// - enabling hands the pin to the transmitter and sends one idle frame.
// - buffer-empty clears only by status access then data write.
// - buffer-empty sets when the buffer drains and a frame starts.
// - buffer-empty with its enable set raises the interrupt request.
// - a write during a frame waits in the buffer until the frame ends.
// - a write while idle starts a frame at once, buffer-empty set.
// - after a stop bit with nothing pending, complete flag and request.
// - the same status-then-write sequence clears the complete flag.
module sat_top #(
  parameter int FIFO_DEPTH = sat_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic       CLK_I,
  input  wire logic       SRST_I,
  // register port
  input  wire logic [2:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  output logic      [7:0] RDATA_O,
  // serial line
  output logic            TXD_O,
  output logic            TXD_OE_O,
  // interrupt request
  output logic            IRQ_O
);

  localparam int LW = $clog2(FIFO_DEPTH+1);

  // --------------------------------------------------------------
  // registers and decode
  // --------------------------------------------------------------
  logic [7:0]             ctrl1_r;
  logic [7:0]             ctrl2_r;
  logic [7:0]             baud_r;
  logic [7:0]             extp_r;
  logic                   buf_empty_r;
  logic                   done_r;
  logic                   armed_r;
  logic [7:0]             rdata_r;
  logic                   irq_r;
  logic                   txd_r;
  logic                   oe_r;
  sat_pkg::sat_state_type state_r;
  logic                   idle_pend_r;
  logic                   tx_en_d_r;
  logic                   frame_idle_r;
  logic [10:0]            shift_r;
  logic [3:0]             bits_left_r;
  logic [15:0]            div_r;

  logic                   wr_data;
  logic                   clear_seq;
  logic                   tx_en;
  logic                   word9;
  logic                   tick;
  logic                   frame_done;
  logic                   load_word;
  logic                   load_idle;
  logic                   fifo_in_ready;
  logic                   fifo_out_valid;
  logic [LW-1:0]          fifo_level;
  sat_pkg::sat_word_type  fifo_in;
  sat_pkg::sat_word_type  fifo_out;
  logic [15:0]            div_reload;

  // one decode for every register write and the status access; the read mux decodes with a case
  function automatic logic hit(input logic [2:0] a, input logic [2:0] reg_a);
    hit = (a == reg_a);
  endfunction : hit

  assign tx_en      = ctrl2_r[sat_pkg::CR2_ENABLE_BIT];
  assign word9      = ctrl1_r[sat_pkg::CR1_WLEN_BIT];
  assign wr_data    = WR_I && hit(ADDR_I, sat_pkg::ADDR_DATA);
  assign clear_seq  = armed_r && wr_data;
  assign div_reload = {extp_r, baud_r};
  assign tick       = (state_r == sat_pkg::TX_SEND) && (div_r == 16'h0000);
  assign frame_done = tick && (bits_left_r == 4'h0);
  assign load_idle  = (state_r == sat_pkg::TX_IDLE) && tx_en && idle_pend_r;
  assign load_word  = (state_r == sat_pkg::TX_IDLE) && tx_en && !idle_pend_r && fifo_out_valid;

  // data register writes go through the buffer; ninth bit sampled at write
  assign fifo_in.ninth = ctrl1_r[sat_pkg::CR1_NINTH_BIT];
  assign fifo_in.data  = WDATA_I;

  // --------------------------------------------------------------
  // transmit buffer
  // --------------------------------------------------------------
  // a write to a full buffer is dropped; software sees the full bit
  sat_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH)
  ) u_buf (
    .clk_i       (CLK_I),
    .srst_i      (SRST_I),
    .in_valid_i  (wr_data),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (fifo_in),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (load_word),
    .out_data_o  (fifo_out),
    .level_o     (fifo_level)
  );

  // --------------------------------------------------------------
  // software registers
  // --------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      ctrl1_r <= sat_pkg::RST_CTRL1;
      ctrl2_r <= sat_pkg::RST_CTRL2;
      baud_r  <= sat_pkg::RST_BAUD;
      extp_r  <= sat_pkg::RST_EXTP;
    end else if (WR_I) begin
      if (hit(ADDR_I, sat_pkg::ADDR_CTRL1)) begin
        ctrl1_r <= WDATA_I;
      end
      if (hit(ADDR_I, sat_pkg::ADDR_CTRL2)) begin
        ctrl2_r <= WDATA_I;
      end
      if (hit(ADDR_I, sat_pkg::ADDR_BAUD)) begin
        baud_r <= WDATA_I;
      end
      if (hit(ADDR_I, sat_pkg::ADDR_EXTP)) begin
        extp_r <= WDATA_I;
      end
    end
  end

  // read data, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      rdata_r <= 8'h00;
    end else if (RD_I) begin
      case (ADDR_I)
        sat_pkg::ADDR_STATUS: rdata_r <= {buf_empty_r, done_r, 5'h00, !fifo_in_ready};
        sat_pkg::ADDR_CTRL1:  rdata_r <= ctrl1_r;
        sat_pkg::ADDR_CTRL2:  rdata_r <= ctrl2_r;
        sat_pkg::ADDR_BAUD:   rdata_r <= baud_r;
        sat_pkg::ADDR_EXTP:   rdata_r <= extp_r;
        default:              rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  // --------------------------------------------------------------
  // status flags and clearing sequence
  // --------------------------------------------------------------
  // a status access arms the clear; the next data write consumes it
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      armed_r <= 1'b0;
    end else if ((RD_I || WR_I) && hit(ADDR_I, sat_pkg::ADDR_STATUS)) begin
      armed_r <= 1'b1;
    end else if (wr_data) begin
      armed_r <= 1'b0;
    end
  end

  // set beats clear when both land in one cycle
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      buf_empty_r <= sat_pkg::RST_TX_BUFFER_EMPTY_FLAG;
    end else if (load_word && fifo_level == LW'(1)) begin
      buf_empty_r <= 1'b1;
    end else if (clear_seq) begin
      buf_empty_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      done_r <= sat_pkg::RST_TC;
    end else if (frame_done && !fifo_out_valid) begin
      done_r <= 1'b1;
    end else if (clear_seq) begin
      done_r <= 1'b0;
    end
  end

  // request level; the cpu-side mask lives outside this block
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= (buf_empty_r && ctrl2_r[sat_pkg::CR2_EMPTY_IE_BIT]) ||
               (done_r && ctrl2_r[sat_pkg::CR2_DONE_IE_BIT]);
    end
  end

  // --------------------------------------------------------------
  // transmitter sequencing
  // --------------------------------------------------------------
  // the enable rising edge queues one idle frame
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      tx_en_d_r   <= 1'b0;
      idle_pend_r <= 1'b0;
    end else begin
      tx_en_d_r <= tx_en;
      if (tx_en && !tx_en_d_r) begin
        idle_pend_r <= 1'b1;
      end else if (load_idle) begin
        idle_pend_r <= 1'b0;
      end
    end
  end

  // state: a running frame always completes even if the enable drops
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      state_r <= sat_pkg::TX_OFF;
    end else begin
      case (state_r)
        sat_pkg::TX_OFF:  state_r <= tx_en ? sat_pkg::TX_IDLE : sat_pkg::TX_OFF;
        sat_pkg::TX_IDLE: begin
          if (!tx_en) begin
            state_r <= sat_pkg::TX_OFF;
          end else if (load_idle || load_word) begin
            state_r <= sat_pkg::TX_SEND;
          end
        end
        sat_pkg::TX_SEND: state_r <= frame_done ? sat_pkg::TX_IDLE : sat_pkg::TX_SEND;
        default:          state_r <= sat_pkg::TX_OFF;
      endcase
    end
  end

  // bit timer: one bit lasts {ext prescaler, baud} + 1 clocks
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      div_r <= 16'h0000;
    end else if (load_idle || load_word || tick) begin
      div_r <= div_reload;
    end else if (state_r == sat_pkg::TX_SEND) begin
      div_r <= div_r - 16'h0001;
    end
  end

  // shifter: bit 0 is the bit now on the line, bit 1 the next, fill with stop level
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      shift_r      <= 11'h7FF;
      bits_left_r  <= 4'h0;
      frame_idle_r <= 1'b0;
    end else if (load_idle) begin
      shift_r      <= 11'h7FF;
      bits_left_r  <= (word9 ? sat_pkg::BITS_FRAME9 : sat_pkg::BITS_FRAME8) - 4'h1;
      frame_idle_r <= 1'b1;
    end else if (load_word) begin
      if (word9) begin
        shift_r <= {1'b1, fifo_out.ninth, fifo_out.data, 1'b0};
      end else begin
        shift_r <= {2'b11, fifo_out.data, 1'b0};
      end
      bits_left_r  <= (word9 ? sat_pkg::BITS_FRAME9 : sat_pkg::BITS_FRAME8) - 4'h1;
      frame_idle_r <= 1'b0;
    end else if (tick && bits_left_r != 4'h0) begin
      shift_r     <= {1'b1, shift_r[10:1]};
      bits_left_r <= bits_left_r - 4'h1;
    end
  end

  // line driver: high whenever no frame is on the wire
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      txd_r <= 1'b1;
      oe_r  <= 1'b0;
    end else begin
      oe_r <= tx_en || (state_r == sat_pkg::TX_SEND);
      if (load_word) begin
        txd_r <= 1'b0;
      end else if (load_idle || frame_done) begin
        txd_r <= 1'b1;
      end else if (tick) begin
        txd_r <= shift_r[1];
      end
    end
  end

  assign RDATA_O  = rdata_r;
  assign TXD_O    = txd_r;
  assign TXD_OE_O = oe_r;
  assign IRQ_O    = irq_r;

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);

  property p_line_idle_high;
    (state_r != sat_pkg::TX_SEND) && !$past(load_word) |-> TXD_O;
  endproperty
  a_line_idle_high: assert property (p_line_idle_high)
    else $error("line not high outside a frame");

  property p_start_bit;
    load_word |=> !TXD_O && (state_r == sat_pkg::TX_SEND);
  endproperty
  a_start_bit: assert property (p_start_bit)
    else $error("start bit missing");

  property p_lsb_first;
    // checked at a bit time of 8 clocks: start bit, then bit 0 nine clocks after the load
    load_word && (div_reload == 16'h0007) |=> ##8 (TXD_O == $past(fifo_out.data[0], 9));
  endproperty
  a_lsb_first: assert property (p_lsb_first)
    else $error("first data bit is not the lsb");

  property p_ninth_bit;
    load_word && word9 |=> shift_r[9] == $past(fifo_out.ninth) && bits_left_r == 4'hA;
  endproperty
  a_ninth_bit: assert property (p_ninth_bit)
    else $error("ninth bit or 9-bit length wrong");

  property p_len8;
    load_word && !word9 |=> bits_left_r == 4'h9 && shift_r[10:9] == 2'b11;
  endproperty
  a_len8: assert property (p_len8)
    else $error("8-bit frame length wrong");

  property p_clear_both;
    clear_seq && !load_word && !frame_done |=> !buf_empty_r && !done_r;
  endproperty
  a_clear_both: assert property (p_clear_both)
    else $error("clear sequence did not clear both flags");

  property p_no_clear_unarmed;
    !armed_r && buf_empty_r |=> buf_empty_r;
  endproperty
  a_no_clear_unarmed: assert property (p_no_clear_unarmed)
    else $error("buffer-empty cleared without status access");

  property p_tx_buffer_empty_flag_set;
    load_word && fifo_level == LW'(1) |=> buf_empty_r;
  endproperty
  a_tx_buffer_empty_flag_set: assert property (p_tx_buffer_empty_flag_set)
    else $error("buffer-empty not set on last word");

  property p_tc_set;
    frame_done && !fifo_out_valid |=> done_r && state_r == sat_pkg::TX_IDLE;
  endproperty
  a_tc_set: assert property (p_tc_set)
    else $error("complete flag not set after stop bit");

  property p_irq;
    buf_empty_r && ctrl2_r[sat_pkg::CR2_EMPTY_IE_BIT] |=> IRQ_O;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt request missing");

  property p_busy_holds;
    wr_data && state_r == sat_pkg::TX_SEND && !frame_done |=> state_r == sat_pkg::TX_SEND && fifo_out_valid;
  endproperty
  a_busy_holds: assert property (p_busy_holds)
    else $error("write during frame disturbed the shifter");

  property p_enable_idle;
    tx_en && !tx_en_d_r && state_r == sat_pkg::TX_OFF |=> oe_r && load_idle;
  endproperty
  a_enable_idle: assert property (p_enable_idle)
    else $error("enable did not start an idle frame");

  c_idle_frame: cover property (load_idle ##[1:1000] frame_done);
  c_word9:      cover property (load_word && word9);
  c_back2back:  cover property (frame_done && fifo_out_valid ##1 load_word);
  c_full:       cover property (!fifo_in_ready && wr_data);

endmodule : sat_top
